// ---- three_phase_gate_ctrl_ocp_tb.sv ----
/*
  Self-checking bench of the three-phase gate control block.
  Assumes a pulled-up fault and warning wire and one 200 MHz clock.
*/
`timescale 1ns/1ps
module three_phase_gate_ctrl_ocp_tb;
  localparam int OCT = 200;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic en = 1'b0, dts = 1'b0, cal = 1'b0, react = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, chi = 3'h0, clo = 3'h0;
  logic [47:0] vds = 48'h0;
  logic hreadyout, hresp, f_out, f_oe, w_out, w_oe, cal_en;
  logic [31:0] hrdata;
  logic [2:0] gh, gl, phi, plo;
  logic [1:0] gain;
  int fail_count = 0, total_checks = 0;
  // Open-drain wires with pull-ups
  wire fault_n = f_oe ? f_out : 1'b1;
  wire warn_n = w_oe ? w_out : 1'b1;

  tpg_top #(.OC_TIMER_CYC(OCT)) u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .high_side_pwm_in(phi),
    .low_side_pwm_in(plo), .en_gate_pin(en), .dead_time_set_pin(dts), .offset_cal_pin(cal),
    .vds_level_in(vds), .high_gate_out(gh), .low_gate_out(gl), .fault_out_n_in(fault_n),
    .fault_out_n_out(f_out), .fault_out_n_oe(f_oe), .warn_out_n_in(warn_n),
    .warn_out_n_out(w_out), .warn_out_n_oe(w_oe), .amp_gain_sel(gain), .amp_cal_en(cal_en));

  tpg_mcu_model u_mcu (.clk(clk), .cmd_hi(chi), .cmd_lo(clo), .react(react),
    .warn_n(warn_n), .pwm_hi(phi), .pwm_lo(plo));

  // Clock of 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Summary and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
  endtask

  // One single-word AHB transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // Expected {high gates, low gates}
  function automatic logic [5:0] exp_g(input logic m3, input logic [2:0] h, input logic [2:0] l);
    if (m3) return {h, ~h};
    return {h & ~l, l & ~h};
  endfunction

  // Phase A: wait for one gate off, then count cycles until the other is on
  task automatic gap(input logic to_lo, output int n);
    n = 0;
    while ((to_lo ? gh[0] : gl[0]) !== 1'b0 && n < 50) begin
      step(1);
      n++;
    end
    chk("gate off", n < 50, 1'b1);
    n = 0;
    while ((to_lo ? gl[0] : gh[0]) !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
  endtask

  // Main sequence
  initial begin
    int n;
    void'($urandom(32'hCE351CFB));
    step(10);
    nrst <= 1'b1;
    en <= 1'b1;
    step(1);
    xfer(1'b0, 32'h0, 32'h0); chk("ctrl reset", rd, 32'h0);
    xfer(1'b0, 32'h8, 32'h0); chk("thr reset", rd, 32'h80);
    xfer(1'b0, 32'hC, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", hresp, 1'b0);
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, 32'h0, 32'(g << 4));
      step(3);
      chk("gain", gain, 32'(g));
    end
    cal <= 1'b1;
    step(6);
    chk("cal pin", cal_en, 1'b1);
    cal <= 1'b0;
    xfer(1'b1, 32'h0, 32'h40); step(3); chk("cal bit", cal_en, 1'b1);
    // Random patterns, six-input then three-input
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 32'h0, (m == 1) ? 32'h8 : 32'h0);
      for (int i = 0; i < 8; i++) begin
        chi <= (i == 0) ? 3'h7 : 3'($urandom);
        clo <= (i == 0) ? 3'h7 : 3'($urandom);
        step(40);
        chk("gates", {gh, gl}, exp_g(m == 1, chi, clo));
      end
    end
    // Dead time from high off to low on
    xfer(1'b1, 32'h0, 32'h0); chi <= 3'h1; clo <= 3'h0; step(40);
    chi <= 3'h0;
    clo <= 3'h1;
    gap(1'b1, n);
    chk("dead time", n >= 10 && n < 50, 1'b1);
    // Dead time from the register field with the pin high
    dts <= 1'b1;
    xfer(1'b1, 32'h0, 32'h1400);
    step(10);
    chi <= 3'h1;
    clo <= 3'h0;
    gap(1'b0, n);
    chk("dead field", n, 32'h14);
    // Latch shutdown, cleared by bit then by enable pulse
    xfer(1'b1, 32'h0, 32'h1); chi <= 3'h1; clo <= 3'h0; step(40);
    for (int k = 0; k < 2; k++) begin
      vds[7:0] <= 8'hFF;
      step(10);
      chk("latch gates", {gh, gl}, 6'h0);
      chk("fault pin", fault_n, 1'b0);
      vds[7:0] <= 8'h0;
      step(20);
      xfer(1'b0, 32'h4, 32'h0); chk("latch stat", rd & 32'h7F, 32'h41);
      if (k == 0) begin
        xfer(1'b1, 32'h0, 32'h81);
      end else begin
        en <= 1'b0;
        step(20);
        en <= 1'b1;
      end
      step(40);
      chk("fault released", fault_n, 1'b1);
      xfer(1'b0, 32'h4, 32'h0); chk("stat cleared", rd & 32'h7F, 32'h0);
      chk("resumed", gh, 3'h1);
    end
    // Report only: warning pulse, gate stays on
    xfer(1'b1, 32'h0, 32'h2); chi <= 3'h0; clo <= 3'h2; step(40);
    vds[31:24] <= 8'hFF;
    step(8);
    chk("report warn", warn_n, 1'b0);
    chk("report gate", gl, 3'h2);
    vds[31:24] <= 8'h0;
    step(OCT - 20);
    chk("warn held", warn_n, 1'b0);
    step(20);
    chk("warn end", warn_n, 1'b1);
    xfer(1'b0, 32'h4, 32'h0); chk("report stat", rd & 32'h7F, 32'h08);
    // Controller reacts to a reported event
    xfer(1'b1, 32'h0, 32'h82); react <= 1'b1; step(20);
    vds[31:24] <= 8'hFF;
    step(20);
    chk("mcu reacts", gl, 3'h0);
    vds[31:24] <= 8'h0;
    react <= 1'b0;
    step(OCT + 10);
    // Disable mode ignores overcurrent
    xfer(1'b1, 32'h0, 32'h83); step(40);
    vds[31:24] <= 8'hFF;
    step(20);
    chk("off warn", warn_n, 1'b1);
    chk("off gate", gl, 3'h2);
    xfer(1'b0, 32'h4, 32'h0); chk("off stat", rd & 32'hFF, 32'h0);
    vds[31:24] <= 8'h0;
    // Cycle-by-cycle limiting
    xfer(1'b1, 32'h0, 32'h80); chi <= 3'h1; clo <= 3'h0; step(40);
    vds[7:0] <= 8'hFF;
    step(10);
    chk("cbc off", gh, 3'h0);
    chk("cbc warn", warn_n, 1'b0);
    vds[7:0] <= 8'h0;
    step(20);
    chk("cbc held", gh, 3'h0);
    xfer(1'b0, 32'h4, 32'h0); chk("cbc stat", rd & 32'h3F, 32'h1);
    chi <= 3'h0;
    step(10);
    chi <= 3'h1;
    step(30);
    chk("cbc back", gh, 3'h1);
    chk("cbc warn end", warn_n, 1'b1);
    // Off-time limiting
    xfer(1'b1, 32'h0, 32'h84); step(40);
    vds[7:0] <= 8'hFF;
    step(10);
    chk("offt off", gh, 3'h0);
    vds[7:0] <= 8'h0;
    step(OCT / 2);
    chk("offt held", gh, 3'h0);
    step(OCT);
    chk("offt back", gh, 3'h1);
    // Off-time: an input cycle re-enables before the timer ends
    vds[7:0] <= 8'hFF;
    step(10);
    chk("offt again", gh, 3'h0);
    vds[7:0] <= 8'h0;
    chi <= 3'h0;
    step(10);
    chi <= 3'h1;
    step(30);
    chk("offt cycle", gh, 3'h1);
    complete_run();
  end
endmodule // three_phase_gate_ctrl_ocp_tb

// ---- tpg_cfg.svh ----
/*
  Offsets, field positions, reset values and timing counts of the
  three-phase gate control block. Assumes a 5 ns system clock.
*/
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

// Clock and timing
`define TPG_CLK_NS 5
`define TPG_DT_MIN_NS 50
`define TPG_DT_MIN_CYC ((`TPG_DT_MIN_NS + `TPG_CLK_NS - 1) / `TPG_CLK_NS)
`define TPG_OC_TIME_NS 64000
`define TPG_OC_TIME_CYC (`TPG_OC_TIME_NS / `TPG_CLK_NS)
`define TPG_QRST_NS 10000
`define TPG_QRST_CYC (`TPG_QRST_NS / `TPG_CLK_NS)

// Register byte offsets
`define TPG_CTRL_OFS 32'h0000_0000
`define TPG_STAT_OFS 32'h0000_0004
`define TPG_THR_OFS 32'h0000_0008

// Control register fields
`define TPG_CTRL_MODE_LSB 0
`define TPG_CTRL_OFFT_BIT 2
`define TPG_CTRL_PWM3_BIT 3
`define TPG_CTRL_GAIN_LSB 4
`define TPG_CTRL_CAL_BIT 6
`define TPG_CTRL_FRST_BIT 7
`define TPG_CTRL_DT_LSB 8

// Reset values
`define TPG_CTRL_RST 16'h0000
`define TPG_THR_RST 8'h80

`endif

// ---- tpg_gate_if.sv ----
/*
  Carrier between the control core and one half-bridge driver.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tpg_gate_if;
  logic want_hi;
  logic want_lo;
  logic [7:0] dt_cyc;
  logic gate_hi;
  logic gate_lo;
  modport ctrl (output want_hi, output want_lo, output dt_cyc, input gate_hi, input gate_lo);
  modport drv (input want_hi, input want_lo, input dt_cyc, output gate_hi, output gate_lo);
endinterface

// ---- tpg_mcu_model.sv ----
/*
  Controller model: drives the PWM pins of the gate control block.
  Assumes the bench hands it per-phase commands on its own clock.
*/
`timescale 1ns/1ps
module tpg_mcu_model (
  input wire logic clk,
  input wire logic [2:0] cmd_hi,
  input wire logic [2:0] cmd_lo,
  input wire logic react,
  input wire logic warn_n,
  output logic [2:0] pwm_hi = 3'h0,
  output logic [2:0] pwm_lo = 3'h0
);
  // Follow commands; on a warning, drop all PWM when reacting
  always @(posedge clk) begin
    pwm_hi <= (react && !warn_n) ? 3'h0 : cmd_hi;
    pwm_lo <= (react && !warn_n) ? 3'h0 : cmd_lo;
  end
endmodule // tpg_mcu_model

// ---- tpg_phase.sv ----
/*
  One half-bridge: break-before-make sequencing with dead time.
  Assumes the core never asks for both gates at once.
*/
`timescale 1ns/1ps
`include "tpg_cfg.svh"
module tpg_phase
  import tpg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  tpg_gate_if.drv gif
);
  localparam int DT_MIN = `TPG_DT_MIN_CYC;
  tpg_gate_state_t st_reg;
  tpg_gate_state_t st_next;
  logic [7:0] cnt_reg;
  logic hi_reg;
  logic lo_reg;
  logic gap_ok;
  logic [7:0] off_run_reg;

  // Dead time elapsed once both gates were off dt_cyc cycles
  assign gap_ok = ({1'b0, cnt_reg} + 9'h001) >= {1'b0, gif.dt_cyc}; // [R01]

  // Turn-on only from the both-off state
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      TPG_GS_DEAD: begin
        if (gif.want_hi && gap_ok) begin
          st_next = TPG_GS_HI; // [R03]
        end else if (gif.want_lo && gap_ok) begin
          st_next = TPG_GS_LO; // [R03]
        end
      end
      TPG_GS_HI: begin
        if (!gif.want_hi) begin
          st_next = TPG_GS_DEAD;
        end
      end
      TPG_GS_LO: begin
        if (!gif.want_lo) begin
          st_next = TPG_GS_DEAD;
        end
      end
      default: begin
        st_next = TPG_GS_DEAD;
      end
    endcase
  end

  // State and gate flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= TPG_GS_DEAD;
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      hi_reg <= (st_next == TPG_GS_HI);
      lo_reg <= (st_next == TPG_GS_LO);
    end
  end

  // Dead-time counter, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
    end else if (st_reg != TPG_GS_DEAD) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hFF) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Helper: run of cycles with both gates off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      off_run_reg <= 8'h00;
    end else if (hi_reg || lo_reg) begin
      off_run_reg <= 8'h00;
    end else if (off_run_reg != 8'hFF) begin
      off_run_reg <= off_run_reg + 8'h01;
    end
  end

  assign gif.gate_hi = hi_reg;
  assign gif.gate_lo = lo_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_no_overlap: assert property (!(hi_reg && lo_reg)) // [R03]
    else $error("both gates of a phase on");
  a_gap_high: assert property ($rose(hi_reg) |-> off_run_reg >= DT_MIN) // [R01] [R02]
    else $error("high gate on before dead time");
  a_gap_low: assert property ($rose(lo_reg) |-> off_run_reg >= DT_MIN) // [R01] [R02]
    else $error("low gate on before dead time");
endmodule // tpg_phase

// ---- tpg_pkg.sv ----
/*
  Types of the three-phase gate control block.
  Assumes nothing of its surroundings.
*/
package tpg_pkg;

  // Overcurrent handling modes
  typedef enum logic [1:0] {
    TPG_OC_LIMIT = 2'b00,
    TPG_OC_LATCH = 2'b01,
    TPG_OC_REPORT = 2'b10,
    TPG_OC_OFF = 2'b11
  } tpg_overcurrent_mode_sel_t;

  // Half-bridge gate states
  typedef enum logic [1:0] {
    TPG_GS_DEAD = 2'b00,
    TPG_GS_HI = 2'b01,
    TPG_GS_LO = 2'b10
  } tpg_gate_state_t;

endpackage

// ---- tpg_sync.sv ----
/*
  Two-flop synchroniser for pin inputs.
  Assumes each bit is a slow level from outside the clock domain.
*/
`timescale 1ns/1ps
module tpg_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule // tpg_sync

// ---- tpg_top.sv ----
/*
  Three-phase gate control with dead time and overcurrent protection,
  AHB-Lite register slave. Assumes one 200 MHz clock, pins
  synchronised here, analog comparator codes as slow levels.
*/
// The register addresses and the AHB-Lite register port were decided locally.
// Overview of operation
// [R01] Keep at least the dead time between one gate off and the other on.
// [R02] With the dead-time pin grounded use the 50 ns minimum.
// [R03] Each half-bridge turns one gate on only after the other is off.
// [R04] Six-input mode: each gate follows its own input.
// [R05] Three-input mode: high input picks high gate, else low gate.
// [R06] Six-input mode, both inputs high: both gates of the phase low.
// [R07] Overcurrent compared only while the gate is on, against a register threshold.
// [R08] Four selectable modes; overcurrent status bits latch until fault reset.
// [R09] Current-limit warning lasts up to 64 us or until next input cycle.
// [R10] A further overcurrent restarts the timer; all affected inputs must cycle.
// [R11] Current-limit mode flags the exact transistor that overcurrented.
// [R12] One bit picks cycle-by-cycle or off-time limiting; cycle-by-cycle after reset.
// [R13] Cycle-by-cycle: only that transistor off until its next input cycle.
// [R14] Off-time: transistor off 64 us; new event restarts timer, both stay off.
// [R15] Off-time: a new input cycle re-enables that transistor early.
// [R16] Latch mode: overcurrent turns off both gates of the half-bridge.
// [R17] Latch mode: fault pin and status stay until fault reset.
// [R18] Report mode: no action, warning low for 64 us, status set.
// [R19] Report mode: the controller itself must react to warnings.
// [R20] Disable mode: overcurrent ignored, no status, no pin.
// [R21] While a fault shutdown is active all gates stay low.
// [R22] Overcurrent reported per transistor in status and on pins.
// [R23] A register field selects amplifier gain 10, 20, 40 or 80.
// [R24] Offset calibration enabled by pin or register bit.
// [R25] A short enable low pulse clears faults without full restart.
// [R26] An error drives gates and fault pin low within 200 ns.
// [R27] Fault reset clears status, releases fault pin, resumes from inputs.
`timescale 1ns/1ps
`include "tpg_cfg.svh"
module tpg_top
  import tpg_pkg::*;
#(
  parameter int OC_TIMER_CYC = `TPG_OC_TIME_CYC,
  parameter int VW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [2:0] high_side_pwm_in,
  input wire logic [2:0] low_side_pwm_in,
  input wire logic en_gate_pin,
  input wire logic dead_time_set_pin,
  input wire logic offset_cal_pin,
  input wire logic [6*VW-1:0] vds_level_in,
  output logic [2:0] high_gate_out,
  output logic [2:0] low_gate_out,
  input wire logic fault_out_n_in,
  output logic fault_out_n_out,
  output logic fault_out_n_oe,
  input wire logic warn_out_n_in,
  output logic warn_out_n_out,
  output logic warn_out_n_oe,
  output logic [1:0] amp_gain_sel,
  output logic amp_cal_en
);
  localparam int TW = $clog2(OC_TIMER_CYC + 1);

  logic [10:0] pin_raw;
  logic [10:0] pin_s;
  logic [6*VW-1:0] vds_s;
  logic [2:0] ih;
  logic [2:0] il;
  logic en_s;
  logic dtp_s;
  logic cal_s;
  logic fpin_s;
  logic wpin_s;
  logic [15:0] ctrl_reg;
  logic [VW-1:0] thr_reg;
  tpg_overcurrent_mode_sel_t mode;
  logic offt;
  logic pwm3;
  logic [7:0] dt_fld;
  logic [7:0] dt_cyc;
  logic ap_take;
  logic wr_pend_reg;
  logic [31:0] wa_reg;
  logic [31:0] rdata;
  logic [31:0] hrdata_reg;
  logic [10:0] status;
  logic wr_ctrl;
  logic wr_thr;
  logic frst_wr;
  logic en_q_reg;
  logic [11:0] low_cnt_reg;
  logic en_rise;
  logic en_long;
  logic fault_rst;
  logic allow;
  logic [5:0] cmd;
  logic [5:0] cmd_q_reg;
  logic [5:0] cyc;
  logic [5:0] over;
  logic [5:0] gate_on;
  logic [5:0] det;
  logic [5:0] det_q_reg;
  logic [5:0] new_oc;
  logic [2:0] kill_set;
  logic limit;
  logic report;
  logic latch;
  logic ev_warn;
  logic [TW-1:0] tmr_reg;
  logic [TW-1:0] tmr_next;
  logic [5:0] pend_reg;
  logic [5:0] pend_next;
  logic [5:0] off_reg;
  logic [5:0] oc_reg;
  logic [2:0] kill_reg;
  logic fault_reg;
  logic warn_reg;
  logic cal_reg;

  // Pin synchronisers
  assign pin_raw = {warn_out_n_in, fault_out_n_in, offset_cal_pin, dead_time_set_pin,
                    en_gate_pin, low_side_pwm_in, high_side_pwm_in};
  tpg_sync #(.W(11)) u_pin_sync (.clk(clk), .nrst(nrst), .d(pin_raw), .q(pin_s));
  tpg_sync #(.W(6*VW)) u_vds_sync (.clk(clk), .nrst(nrst), .d(vds_level_in), .q(vds_s));
  assign ih = pin_s[2:0];
  assign il = pin_s[5:3];
  assign en_s = pin_s[6];
  assign dtp_s = pin_s[7];
  assign cal_s = pin_s[8];
  assign fpin_s = pin_s[9];
  assign wpin_s = pin_s[10];

  // Control fields
  assign mode = tpg_overcurrent_mode_sel_t'(ctrl_reg[`TPG_CTRL_MODE_LSB +: 2]); // [R08]
  assign offt = ctrl_reg[`TPG_CTRL_OFFT_BIT]; // [R12]
  assign pwm3 = ctrl_reg[`TPG_CTRL_PWM3_BIT];
  assign dt_fld = ctrl_reg[`TPG_CTRL_DT_LSB +: 8];
  assign limit = (mode == TPG_OC_LIMIT);
  assign report = (mode == TPG_OC_REPORT);
  assign latch = (mode == TPG_OC_LATCH);

  // Dead time: minimum when the pin is grounded, else field, never below it
  always_comb begin
    dt_cyc = 8'(`TPG_DT_MIN_CYC); // [R02]
    if (dtp_s && (dt_fld > 8'(`TPG_DT_MIN_CYC))) begin
      dt_cyc = dt_fld; // [R01]
    end
  end

  // AHB-Lite address phase, zero wait states
  assign ap_take = hsel && htrans[1] && hready;
  assign status = {wpin_s, fpin_s, en_s, warn_reg, fault_reg, oc_reg};

  // Read decode, unmapped reads as zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (haddr == `TPG_CTRL_OFS) begin
      rdata = {16'h0000, ctrl_reg};
    end else if (haddr == `TPG_STAT_OFS) begin
      rdata = {21'h000000, status}; // [R22]
    end else if (haddr == `TPG_THR_OFS) begin
      rdata = {{(32-VW){1'b0}}, thr_reg};
    end
  end

  // Bus pipeline flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wa_reg <= 32'h0000_0000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ap_take && hwrite;
      if (ap_take) begin
        wa_reg <= haddr;
      end
      if (ap_take && !hwrite) begin
        hrdata_reg <= rdata;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign wr_ctrl = wr_pend_reg && (wa_reg == `TPG_CTRL_OFS);
  assign wr_thr = wr_pend_reg && (wa_reg == `TPG_THR_OFS);
  assign frst_wr = wr_ctrl && hwdata[`TPG_CTRL_FRST_BIT];

  // Control register; reset bit self-clears, long enable low restores defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `TPG_CTRL_RST; // [R12]
    end else if (en_long) begin
      ctrl_reg <= `TPG_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata[15:0];
      ctrl_reg[`TPG_CTRL_FRST_BIT] <= 1'b0;
    end
  end

  // Overcurrent threshold register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thr_reg <= VW'(`TPG_THR_RST);
    end else if (wr_thr) begin
      thr_reg <= hwdata[VW-1:0]; // [R07]
    end
  end

  // Enable pin low time, measured for the quick reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q_reg <= 1'b0;
      low_cnt_reg <= 12'h000;
    end else begin
      en_q_reg <= en_s;
      if (en_s) begin
        low_cnt_reg <= 12'h000;
      end else if (low_cnt_reg != 12'hFFF) begin
        low_cnt_reg <= low_cnt_reg + 12'h001;
      end
    end
  end

  assign en_rise = en_s && !en_q_reg;
  assign en_long = en_rise && (low_cnt_reg > 12'(`TPG_QRST_CYC));
  assign fault_rst = frst_wr || en_rise; // [R25] [R27]
  assign allow = en_s && !fault_reg; // [R21]

  // Per-phase input map, comparators and drivers
  for (genvar p = 0; p < 3; p++) begin : g_ph
    tpg_gate_if gif ();
    // 3-input: high input only; 6-input: each own, both high gives both off
    assign cmd[2*p] = pwm3 ? ih[p] : (ih[p] && !il[p]); // [R04] [R05] [R06]
    assign cmd[2*p+1] = pwm3 ? !ih[p] : (il[p] && !ih[p]); // [R04] [R05] [R06]
    assign over[2*p] = vds_s[2*p*VW +: VW] > thr_reg; // [R07]
    assign over[2*p+1] = vds_s[(2*p+1)*VW +: VW] > thr_reg; // [R07]
    assign kill_set[p] = latch && (det[2*p] || det[2*p+1]); // [R16]
    assign gif.want_hi = cmd[2*p] && !off_reg[2*p] && !kill_reg[p] && allow; // [R13]
    assign gif.want_lo = cmd[2*p+1] && !off_reg[2*p+1] && !kill_reg[p] && allow; // [R16]
    assign gif.dt_cyc = dt_cyc;
    assign gate_on[2*p] = gif.gate_hi;
    assign gate_on[2*p+1] = gif.gate_lo;
    assign high_gate_out[p] = gif.gate_hi;
    assign low_gate_out[p] = gif.gate_lo;
    tpg_phase u_phase (.clk(clk), .nrst(nrst), .gif(gif));
  end

  // Detection only on a conducting gate, nothing in disable mode
  assign det = gate_on & over & {6{mode != TPG_OC_OFF}}; // [R07] [R20]
  assign cyc = cmd & ~cmd_q_reg;
  assign new_oc = det & ~det_q_reg;
  assign ev_warn = (|new_oc) && (limit || report);

  // Edge history of commands and detections
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q_reg <= 6'h00;
      det_q_reg <= 6'h00;
    end else begin
      cmd_q_reg <= cmd;
      det_q_reg <= det;
    end
  end

  // Shared 64 us timer, restarted by every new event in current-limit or report mode
  always_comb begin
    tmr_next = tmr_reg;
    if (ev_warn) begin
      tmr_next = TW'(OC_TIMER_CYC); // [R09] [R10] [R14] [R18]
    end else if (fault_rst || !(limit || report)) begin
      tmr_next = '0;
    end else if (tmr_reg != '0) begin
      tmr_next = tmr_reg - TW'(1);
    end
  end

  // Transistors whose warning waits for their next input cycle
  always_comb begin
    pend_next = 6'h00;
    if (limit && (tmr_next != '0)) begin
      pend_next = (pend_reg & ~cyc) | new_oc; // [R09] [R10]
    end
  end

  // Timer, pending set and warning flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_reg <= '0;
      pend_reg <= 6'h00;
      warn_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      pend_reg <= pend_next;
      warn_reg <= (tmr_next != '0) && (report || (|pend_next)); // [R09] [R18]
    end
  end

  // Current-limit disables; set wins over every clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      off_reg <= 6'h00;
    end else if (!limit) begin
      off_reg <= 6'h00;
    end else if (fault_rst || (offt && (tmr_next == '0))) begin
      off_reg <= det; // [R14]
    end else begin
      off_reg <= (off_reg & ~cyc) | det; // [R13] [R15]
    end
  end

  // Latched status, phase kill and fault; set wins over reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_reg <= 6'h00;
      kill_reg <= 3'h0;
      fault_reg <= 1'b0;
    end else begin
      oc_reg <= (fault_rst ? 6'h00 : oc_reg) | det; // [R08] [R11] [R22] [R27]
      kill_reg <= (fault_rst ? 3'h0 : kill_reg) | kill_set; // [R16]
      fault_reg <= (fault_rst ? 1'b0 : fault_reg) | (|kill_set); // [R17] [R26]
    end
  end

  // Amplifier controls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_reg <= 1'b0;
    end else begin
      cal_reg <= cal_s || ctrl_reg[`TPG_CTRL_CAL_BIT]; // [R24]
    end
  end

  assign amp_cal_en = cal_reg;
  assign amp_gain_sel = ctrl_reg[`TPG_CTRL_GAIN_LSB +: 2]; // [R23]

  // Open-drain pins pull low only
  assign fault_out_n_out = 1'b0;
  assign fault_out_n_oe = fault_reg; // [R17] [R26]
  assign warn_out_n_out = 1'b0;
  assign warn_out_n_oe = warn_reg; // [R22]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_latch_hit;
    latch && (|det);
  endsequence
  sequence s_cbc_hit;
    limit && !offt && (|det);
  endsequence
  sequence s_warn_ev;
    (|new_oc) && (limit || report);
  endsequence

  a_fault_gates: assert property (fault_reg |=> !(|{high_gate_out, low_gate_out})) // [R21]
    else $error("gate on during fault");
  a_latch_fault: assert property (s_latch_hit |=> fault_reg && fault_out_n_oe) // [R16] [R17]
    else $error("latch overcurrent not latched");
  a_status_set: assert property ((|det) |=> ((oc_reg & $past(det)) == $past(det))) // [R11]
    else $error("status bit missed");
  a_oc_quiet: assert property ((mode == TPG_OC_OFF) && !fault_rst |=> $stable(oc_reg)) // [R20]
    else $error("status changed in disable mode");
  a_warn_start: assert property (s_warn_ev |=> warn_out_n_oe) // [R09]
    else $error("warning not raised");
  a_report_pulse: assert property (report && (|new_oc) |=> warn_out_n_oe [*8]) // [R18]
    else $error("report pulse too short");
  a_cbc_off: assert property (s_cbc_hit |=> ((off_reg & $past(det)) == $past(det))) // [R13]
    else $error("limited transistor not held off");
  a_frst_clear: assert property (fault_rst && !(|det) |=> !(|oc_reg) && !fault_reg) // [R27]
    else $error("fault reset left status");
  a_quick_rst: assert property (en_rise |=> !fault_reg) // [R25]
    else $error("enable pulse did not clear fault");
  a_six_both: assert property (!pwm3 && ih[0] && il[0] |=> !(|gate_on[1:0])) // [R06]
    else $error("both inputs high drove a gate");
endmodule // tpg_top
